// file: bench/tb.sv
// Purpose: Self-checking bench for the trace output port.
// Assumes: Tie-offs change only while reset is held.
// Notes:   Trigger pulses stand long enough for the input synchroniser.
`timescale 1ns/1ns
`default_nettype none
module tb
    import trace_port_pkg::*;
;
    logic aclk = 1'h0, aresetn = 1'h0, trigger_in = 1'h0, flush_done = 1'h0, flush_in = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ctl_pin_present = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ext_ctl_in = 8'h00, ext_ctl_out;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, trace_data;
    logic [4:0] max_data_index = 5'h1F;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic flush_request, trace_clock, trace_ctl;
    int n_mismatch = 0, cmp_count = 0;
    trace_out_port #(.DATA_W(32)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .ctl_pin_present, .max_data_index, .trigger_in, .flush_in, .flush_request,
        .flush_done, .ext_ctl_in, .ext_ctl_out, .trace_clock, .trace_data, .trace_ctl);
    trace_analyzer_model #(.DATA_W(32)) am (.trace_clock, .trace_data, .trace_ctl);
    always #50 aclk = ~aclk;
    // =========================================================================
    // Checking and bus tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    task automatic bound(input int n);
        if (n >= 40) begin
            check("wait bound", 32'h0, 32'h1);
            final_report();
        end
    endtask : bound
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && n < 40);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge aclk);
        bound(n);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && n < 40);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
        bound(n);
    endtask : axi_rd
    // =========================================================================
    // Trace side helpers
    function automatic logic [31:0] masked(input logic [31:0] d, input logic [4:0] m);
        return d & 32'((64'h1 << (m + 6'h1)) - 64'h1);
    endfunction : masked
    task automatic fire(input logic f = 1'h0);
        trigger_in <= !f;
        flush_in <= f;
        repeat (4) @(posedge aclk);
        trigger_in <= 1'h0;
        flush_in <= 1'h0;
    endtask : fire
    task automatic pins(input logic c, input logic [31:0] d);
        int n;
        n = 0;
        while ((am.last_ctl !== c || am.last_data !== d) && n < 40) begin
            @(posedge aclk);
            n++;
        end
        check("trace ctl", 32'(c), 32'(am.last_ctl));
        check("trace data", d, am.last_data);
    endtask : pins
    // A missing trigger is expected in some passes, so the window is not fatal there.
    task automatic trig_seen(input int base, input int exp);
        int n;
        n = 0;
        while (am.n_trig == base && n < 40) begin
            @(posedge aclk);
            n++;
        end
        if (exp > 0) bound(n);
        check("trigger count", 32'(exp), 32'(am.n_trig - base));
    endtask : trig_seen
    initial begin
        logic [31:0] d, e;
        logic [1:0] r;
        int bt, bc, n;
        d = $urandom(32'hCB8CC539);
        for (int p = 0; p < 2; p++) begin
            ctl_pin_present <= (p == 0);
            max_data_index <= 5'($urandom_range(31, 1));
            ext_ctl_in <= 8'($urandom);
            aresetn <= 1'h0;
            repeat (3) @(posedge aclk);
            aresetn <= 1'h1;
            @(posedge aclk);
            axi_rd(OFS_STATUS, d, r);
            check("status ctl pin", 32'(p == 0), 32'(d[STS_CTL_PIN]));
            axi_rd(OFS_PORT_SIZE, d, r);
            check("port size", 32'(max_data_index), d);
            axi_wr(OFS_CONTROL, 32'(MODE_NORMAL), r);
            check("write resp", 32'(RESP_OKAY), 32'(r));
            if (p == 0) pins(1'h1, 32'h1);
            for (int m = 0; m < 3; m++) begin
                d = $urandom;
                axi_wr(OFS_DATA, d, r);
                e = 32'(m) | (32'h1 << CTL_ENABLE) | (32'h1 << CTL_TRG_DIRECT);
                axi_wr(OFS_CONTROL, e, r);
                pins(1'h0, masked(d, max_data_index));
                bt = am.n_trig;
                bc = am.n_ctl;
                fire();
                trig_seen(bt, (p == 0 && m < 2) ? 1 : 0);
                check("ctl samples", (p == 0 && m < 2) ? 1 : 0, am.n_ctl - bc);
            end
            axi_rd(OFS_STATUS, d, r);
            check("status triggered", 32'h1, 32'(d[STS_TRIGGERED]));
            axi_wr(OFS_TRIG_CNT, 32'($urandom_range(20, 0)), r);
            e = (32'h1 << CTL_ENABLE) | (32'h1 << CTL_TRG_ON_TRG) | 32'(MODE_NORMAL);
            axi_wr(OFS_CONTROL, e, r);
            bt = am.n_trig;
            fire();
            trig_seen(bt, (p == 0) ? 1 : 0);
            e = (32'h1 << CTL_ENABLE) | (32'h1 << CTL_FLUSH_ON_TRG) | (32'h1 << CTL_TRG_ON_FLUSH);
            axi_wr(OFS_CONTROL, e | 32'(MODE_NORMAL), r);
            bt = am.n_trig;
            fire();
            for (n = 0; flush_request !== 1'h1 && n < 40; n++) @(posedge aclk);
            bound(n);
            check("early trigger", 32'(bt), 32'(am.n_trig));
            flush_done <= 1'h1;
            @(posedge aclk);
            flush_done <= 1'h0;
            trig_seen(bt, (p == 0) ? 1 : 0);
            check("flush released", 32'h0, 32'(flush_request));
            e = (32'h1 << CTL_ENABLE) | (32'h1 << CTL_TRG_ON_FLUSH) | 32'(MODE_NORMAL);
            axi_wr(OFS_CONTROL, e, r);
            bt = am.n_trig;
            fire(1'h1);
            check("flush in request", 32'h1, 32'(flush_request));
            flush_done <= 1'h1;
            @(posedge aclk);
            flush_done <= 1'h0;
            trig_seen(bt, (p == 0) ? 1 : 0);
            e = 32'($urandom_range(255, 0));
            axi_wr(OFS_EXT_CTL, e, r);
            axi_rd(OFS_EXT_CTL, d, r);
            check("ext out", e, 32'(ext_ctl_out));
            check("ext readback", {16'h0, ext_ctl_in, e[7:0]}, {16'h0, d[15:0]});
            axi_rd(8'h3C, d, r);
            check("unmapped read", 32'(RESP_SLVERR), 32'(r));
            axi_wr(8'h40, 32'h0, r);
            check("unmapped write", 32'(RESP_SLVERR), 32'(r));
        end
        final_report();
    end
endmodule : tb
`default_nettype wire

// file: bench/trace_analyzer_model.sv
// Purpose: Behavioural trace capture analyzer on the trace pins.
// Assumes: Pins settle within 10 ns of each trace clock edge.
// Notes:   Counts trigger codes and control-pin samples.
`timescale 1ns/1ns
`default_nettype none
module trace_analyzer_model #(
    parameter int DATA_W = 32
) (
    // Trace pins
    input wire logic              trace_clock,
    input wire logic [DATA_W-1:0] trace_data,
    input wire logic              trace_ctl
);
    int                n_trig    = 0;
    int                n_ctl     = 0;
    logic              last_ctl  = 1'h0;
    logic [DATA_W-1:0] last_data = '0;
    // Waiting 10 ns keeps the sample clear of the launching edge.
    always @(trace_clock) begin
        #10;
        last_ctl = trace_ctl;
        last_data = trace_data;
        if (trace_ctl === 1'h1) n_ctl++;
        if (trace_ctl === 1'h1 && trace_data[1:0] === 2'h2) n_trig++;
    end
endmodule : trace_analyzer_model
`default_nettype wire

// file: bench/trace_port_monitor.sv
// Purpose: Concurrent checks on the trace port pins and bus answers.
// Assumes: Tie-offs are static while out of reset.
// Notes:   Checks on the trace clock wait until the port has settled.
`timescale 1ns/1ns
`default_nettype none
module trace_port_monitor #(
    parameter int DATA_W = 32
) (
    // Clock, reset and bus
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    // Tie-offs, flush and pins
    input wire logic              ctl_pin_present,
    input wire logic [4:0]        max_data_index,
    input wire logic              flush_request,
    input wire logic              flush_done,
    input wire logic [7:0]        ext_ctl_out,
    input wire logic              trace_clock,
    input wire logic [DATA_W-1:0] trace_data,
    input wire logic              trace_ctl
);
    logic [1:0]        up_cnt;
    logic              settled;
    logic              w_hs;
    logic [DATA_W-1:0] hi_mask;
    assign settled = up_cnt == 2'h3;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign hi_mask = DATA_W'(~((64'h1 << (max_data_index + 6'h1)) - 64'h1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h3) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // =========================================================================
    // Pin checks
    chk_clock_halves: assert property (
        settled |-> trace_clock != $past(trace_clock)) else $error("trace clock stalled");
    chk_ctl_absent: assert property (
        !ctl_pin_present |-> !trace_ctl) else $error("control pin used while absent");
    chk_upper_quiet: assert property (
        (trace_data & hi_mask) == '0) else $error("unwired data bits moved");
    chk_trig_pulse: assert property (
        trace_ctl && trace_data[1:0] == 2'h2 |=> !(trace_ctl && trace_data[1:0] == 2'h2))
        else $error("trigger code longer than one cycle");
    chk_flush_hold: assert property (
        flush_request && !flush_done |=> flush_request) else $error("flush request dropped");
    chk_ext_cause: assert property (
        settled && $changed(ext_ctl_out) |-> $past(w_hs) || $past(w_hs, 2))
        else $error("external control changed without a write");
    // =========================================================================
    // Bus answers
    chk_write_answer: assert property (
        w_hs |-> ##[1:3] s_axi_bvalid) else $error("write response missing");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
    chk_resp_release: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response stuck");
endmodule : trace_port_monitor
bind trace_out_port trace_port_monitor #(.DATA_W(DATA_W)) u_mon (.aclk, .aresetn,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .ctl_pin_present, .max_data_index, .flush_request,
    .flush_done, .ext_ctl_out, .trace_clock, .trace_data, .trace_ctl);
`default_nettype wire

// file: hdl/trace_out_port.sv
// Purpose: Trace output port with control pin encoding and trigger logic.
// Assumes: Tie-off inputs are static; flush_done is a pulse on aclk.
// Notes:   Data and control change on both edges of the divided clock.
//
// What the document specifies
// R1: Divide source clock by two; DDR data.
// R2: Analyzer samples on both exported clock edges.
// R3: Provide 32-bit trace data output bus.
// R4: Control-pin tie-off shown in status bit 2.
// R5: Width tie-off sets reported port size.
// R6: Integrator wires two bits with control pin.
// R7: Support with-control and data-only configurations.
// R8: No phase offset between clock and data.
// R9: Analyzer tolerates any clock alignment.
// R10: Encode control only in bypass/normal mode.
// R11: Control/data[1:0] encode trigger and capture.
// R12: Legacy analyzer captures by control pin.
// R13: Signal trigger only when safe to stop.
// R14: Trigger direct, counter-delayed, or on flush.
// R15: Trigger requests flush when configured.
// R16: Flush-on-trigger defers trigger until flush done.
// R17: Synchronise trigger and flush request inputs.
// R18: Pass 8-bit external control in and out.
// R19: Analyzer may drive clock and probe patterns.
// R20: Crossing between port and bus domains.
// R21: Control-only analyzers avoid continuous mode.
// R22: Hold unconnected upper data bits constant.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module trace_out_port
    import trace_port_pkg::*;
#(
    parameter int DATA_W = 32
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address, data and response
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Tie-offs
    input  wire logic              ctl_pin_present,
    input  wire logic [4:0]        max_data_index,
    // Cross-trigger events from another domain
    input  wire logic              trigger_in,
    input  wire logic              flush_in,
    // Trace bus flush handshake
    output logic                   flush_request,
    input  wire logic              flush_done,
    // External pin multiplex control
    input  wire logic [7:0]        ext_ctl_in,
    output logic [7:0]             ext_ctl_out,
    // Trace pins
    output logic                   trace_clock,
    output logic [DATA_W-1:0]      trace_data,
    output logic                   trace_ctl
);
    // =========================================================================
    // Registers
    logic [31:0]       control_reg;
    logic [31:0]       data_word_reg;
    logic [15:0]       trig_cnt_reg;
    logic [7:0]        ext_ctl_reg;
    logic [7:0]        ext_in_reg;
    logic [7:0]        ext_meta_reg;
    logic              triggered_reg;
    logic              stopped_reg;
    logic              flush_busy_reg;
    logic              trig_pend_reg;
    logic              defer_reg;
    logic [15:0]       delay_cnt_reg;
    logic              delay_run_reg;
    logic              trig_show_reg;
    logic [1:0]        trig_sync_reg;
    logic [1:0]        flush_sync_reg;
    logic              trig_prev_reg;
    logic              flush_prev_reg;
    logic              aw_hold_reg;
    logic              w_hold_reg;
    logic [7:0]        aw_addr_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;

    logic [1:0] mode;
    logic       encode_on;
    logic       trig_evt;
    logic       flush_evt;
    logic       fire_trig;
    logic       manual_flush;
    logic       do_write;
    logic [DATA_W-1:0] width_mask;

    assign mode     = control_reg[CTL_MODE_LO+1:CTL_MODE_LO];
    assign encode_on = ctl_pin_present && (mode == MODE_BYPASS || mode == MODE_NORMAL); // [R10]
    assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

    // =========================================================================
    // Event synchronisers; only the second stage is examined.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_sync_reg  <= 2'h0;
            flush_sync_reg <= 2'h0;
            trig_prev_reg  <= 1'b0;
            flush_prev_reg <= 1'b0;
            ext_meta_reg   <= 8'h00;
            ext_in_reg     <= 8'h00;
        end else begin
            trig_sync_reg  <= {trig_sync_reg[0], trigger_in};   // [R17] [R20]
            flush_sync_reg <= {flush_sync_reg[0], flush_in};    // [R17]
            trig_prev_reg  <= trig_sync_reg[1];
            flush_prev_reg <= flush_sync_reg[1];
            ext_meta_reg   <= ext_ctl_in;                       // [R18]
            ext_in_reg     <= ext_meta_reg;
        end
    end
    assign trig_evt  = trig_sync_reg[1] && !trig_prev_reg;
    assign flush_evt = flush_sync_reg[1] && !flush_prev_reg;
    assign manual_flush = do_write && aw_addr_reg == OFS_CONTROL && w_strb_reg[0]
                          && w_data_reg[CTL_FLUSH_MANUAL];

    // =========================================================================
    // Flush scheduling: a request masks further ones until it completes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flush_busy_reg <= 1'b0;
            defer_reg      <= 1'b0;
        end else begin
            if (flush_busy_reg && flush_done) begin
                flush_busy_reg <= 1'b0;
                defer_reg      <= 1'b0;
            end else if (!flush_busy_reg) begin
                if (trig_evt && control_reg[CTL_FLUSH_ON_TRG]) begin
                    flush_busy_reg <= 1'b1;                     // [R15]
                    defer_reg      <= 1'b1;                     // [R16]
                end else if (flush_evt || manual_flush) begin
                    flush_busy_reg <= 1'b1;
                end
            end
        end
    end

    // =========================================================================
    // Trigger causes: direct, counter-delayed, or flush completion.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            delay_cnt_reg <= 16'h0000;
            delay_run_reg <= 1'b0;
        end else if (trig_evt && control_reg[CTL_TRG_ON_TRG] && !delay_run_reg) begin
            delay_cnt_reg <= trig_cnt_reg;
            delay_run_reg <= 1'b1;
        end else if (delay_run_reg && delay_cnt_reg != 16'h0000) begin
            delay_cnt_reg <= delay_cnt_reg - 16'h0001;
        end else begin
            delay_run_reg <= 1'b0;
        end
    end

    // A trigger deferred behind its own flush waits for flush_done.
    assign fire_trig =
        (trig_evt && control_reg[CTL_TRG_DIRECT] && !control_reg[CTL_FLUSH_ON_TRG])   // [R14]
        || (delay_run_reg && delay_cnt_reg == 16'h0000 && !defer_reg)                // [R14]
        || (flush_busy_reg && flush_done
            && (control_reg[CTL_TRG_ON_FLUSH] || defer_reg));                        // [R14] [R16]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_pend_reg <= 1'b0;
            triggered_reg <= 1'b0;
        end else begin
            if (fire_trig) begin
                trig_pend_reg <= 1'b1;                          // [R13]
                triggered_reg <= 1'b1;
            end else if (trig_show_reg) begin
                trig_pend_reg <= 1'b0;
            end
        end
    end

    // =========================================================================
    // Port clock divider and DDR output; data and control change with the clock.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trace_clock   <= 1'b0;
            trace_data    <= '0;
            trace_ctl     <= 1'b0;
            trig_show_reg <= 1'b0;
            stopped_reg   <= 1'b0;
        end else begin
            trace_clock   <= ~trace_clock;                      // [R1] [R8]
            trig_show_reg <= 1'b0;
            if (!control_reg[CTL_ENABLE] || stopped_reg) begin
                trace_ctl  <= encode_on;                        // [R11]
                trace_data <= encode_on ? DATA_W'(1) : '0;      // [R11]
            // A marker already shown is skipped while its pending flag clears,
            // so the trigger code stands for exactly one cycle.
            end else if (trig_pend_reg && !trig_show_reg && encode_on) begin
                trace_ctl     <= 1'b1;                          // [R11] [R13]
                trace_data    <= DATA_W'(2);
                trig_show_reg <= 1'b1;
            end else begin
                trace_ctl  <= 1'b0;                             // [R11] [R7]
                trace_data <= data_word_reg[DATA_W-1:0] & width_mask;  // [R3] [R22]
                if (trig_pend_reg && !trig_show_reg) begin
                    trig_show_reg <= 1'b1;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < DATA_W; i++) begin
            width_mask[i] = (i <= int'(max_data_index));        // [R22]
        end
    end

    // =========================================================================
    // AXI4-Lite slave: address and data taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            aw_addr_reg  <= 8'h00;
            w_data_reg   <= 32'h0000_0000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg == OFS_CONTROL || aw_addr_reg == OFS_EXT_CTL
                                 || aw_addr_reg == OFS_DATA || aw_addr_reg == OFS_TRIG_CNT
                                 || aw_addr_reg == OFS_STATUS || aw_addr_reg == OFS_PORT_SIZE)
                                ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_reg && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_hold_reg && !s_axi_wready && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_reg   <= CONTROL_RESET;
            data_word_reg <= 32'h0000_0000;
            trig_cnt_reg  <= TRIG_CNT_RESET;
            ext_ctl_reg   <= 8'h00;
        end else if (do_write) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb_reg[b]) begin
                    unique case (aw_addr_reg)
                        OFS_CONTROL:  control_reg[b*8 +: 8]   <= w_data_reg[b*8 +: 8];
                        OFS_DATA:     data_word_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
                        OFS_TRIG_CNT: if (b < 2) trig_cnt_reg[b*8 +: 8] <= w_data_reg[b*8 +: 8];
                        OFS_EXT_CTL:  if (b == 0) ext_ctl_reg <= w_data_reg[7:0];  // [R18]
                        default:      ;
                    endcase
                end
            end
            control_reg[CTL_FLUSH_MANUAL] <= 1'b0;
        end
    end
    assign ext_ctl_out = ext_ctl_reg;

    // Read channel.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                unique case (s_axi_araddr)
                    OFS_CONTROL:   s_axi_rdata <= control_reg;
                    OFS_STATUS:    s_axi_rdata <= {28'h0, stopped_reg, ctl_pin_present,  // [R4]
                                                   triggered_reg, flush_busy_reg};
                    OFS_PORT_SIZE: s_axi_rdata <= {27'h0, max_data_index};   // [R5]
                    OFS_EXT_CTL:   s_axi_rdata <= {16'h0, ext_in_reg, ext_ctl_reg};
                    OFS_DATA:      s_axi_rdata <= data_word_reg;
                    OFS_TRIG_CNT:  s_axi_rdata <= {16'h0, trig_cnt_reg};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign flush_request = flush_busy_reg;                      // [R15]
endmodule : trace_out_port
`default_nettype wire

// file: hdl/trace_port_pkg.sv
// Purpose: Shared constants for the trace output port block.
// Assumes: One 10 MHz clock, AXI4-Lite register access with 32-bit data.
// Notes:   Offsets are byte addresses of aligned words.
package trace_port_pkg;
    // =========================================================================
    // Register map
    localparam logic [7:0] OFS_CONTROL   = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_PORT_SIZE = 8'h08;
    localparam logic [7:0] OFS_EXT_CTL   = 8'h0C;
    localparam logic [7:0] OFS_DATA      = 8'h10;
    localparam logic [7:0] OFS_TRIG_CNT  = 8'h14;
    // =========================================================================
    // Control register fields
    localparam int CTL_MODE_LO      = 0;
    localparam int CTL_FLUSH_ON_TRG = 2;
    localparam int CTL_TRG_ON_TRG   = 3;
    localparam int CTL_TRG_ON_FLUSH = 4;
    localparam int CTL_TRG_DIRECT   = 5;
    localparam int CTL_ENABLE       = 6;
    localparam int CTL_FLUSH_MANUAL = 7;
    // Formatter modes.
    localparam logic [1:0] MODE_BYPASS     = 2'h0;
    localparam logic [1:0] MODE_NORMAL     = 2'h1;
    localparam logic [1:0] MODE_CONTINUOUS = 2'h2;
    // =========================================================================
    // Status register fields
    localparam int STS_FLUSH_BUSY = 0;
    localparam int STS_TRIGGERED  = 1;
    localparam int STS_CTL_PIN    = 2;
    localparam int STS_STOPPED    = 3;
    // Reset values.
    localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
    localparam logic [15:0] TRIG_CNT_RESET = 16'h0000;
    // Response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : trace_port_pkg
